/* design/pffp_pkg.sv */
// Package for the prefetch fill policy block: request and eviction carriers.
// Assumes a 48-bit physical address and 64-byte lines.
package pffp_pkg;
  localparam int ADDR_W     = 48;
  localparam int LINE_OFS_W = 6;
  // 64 KiB total over two ways gives 32 KiB per way, so 512 sets.
  localparam int TOTAL_BYTES = 65536;
  localparam int NUM_WAYS    = 2;
  localparam int WAY_BYTES   = TOTAL_BYTES / NUM_WAYS;
  localparam int SET_W       = 9;
  localparam int TAG_W       = ADDR_W - SET_W - LINE_OFS_W;
  localparam int SET_LSB     = LINE_OFS_W;
  localparam int TAG_LSB     = LINE_OFS_W + SET_W;

  // Prefetch request kinds.
  localparam logic [2:0] KIND_PLAIN = 3'h0;
  localparam logic [2:0] KIND_HINT0 = 3'h1;
  localparam logic [2:0] KIND_HINT1 = 3'h2;
  localparam logic [2:0] KIND_HINT2 = 3'h3;
  localparam logic [2:0] KIND_WRITE = 3'h4;
  localparam logic [2:0] KIND_NTMP  = 3'h5;

  // Request from the load/store pipeline.
  typedef struct packed {
    logic [2:0]        kind;
    logic [ADDR_W-1:0] addr;
    logic              l2_hit;  // Line already present in second level.
    logic              hw;      // Issued by the hardware stream prefetcher.
    logic              hw_nt;   // Stream carries the nontemporal tag.
  } pffp_req_t;

  // Fill written into the first-level data cache.
  typedef struct packed {
    logic              valid;
    logic [SET_W-1:0]  set;
    logic [TAG_W-1:0]  tag;
    logic              way;
    logic              modified;
    logic              nontemporal_tag;
    logic              in_l2;
  } pffp_fill_t;

  // Eviction outcome toward the second-level cache.
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic              install_l2;
    logic              dirty;
  } pffp_evict_t;

  // Training event for the stream prefetcher.
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic              nontemporal_tag;
  } pffp_train_t;
endpackage : pffp_pkg

/* design/pffp_fill_policy.sv */
// Fill and eviction policy of the first-level data cache for prefetches.
// Assumes one request per cycle from logic on sys_clk; the line data itself
// arrives elsewhere; this block keeps tags, states and policy flags.
`timescale 1ns/1ps
`default_nettype none
module pffp_fill_policy (
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // Prefetch requests.
  input  wire logic                  req_valid,
  input  var  pffp_pkg::pffp_req_t   req,
  // Results.
  output var  pffp_pkg::pffp_fill_t  fill_q,
  output var  pffp_pkg::pffp_evict_t evict_q,
  output var  pffp_pkg::pffp_train_t train_q,
  output logic                       hit_q
);
  localparam int SETS = 1 << pffp_pkg::SET_W;

  logic [pffp_pkg::TAG_W-1:0] tag_mem [SETS][pffp_pkg::NUM_WAYS];
  logic [SETS-1:0] vld0_q, vld1_q, mod0_q, mod1_q;
  logic [SETS-1:0] nt0_q, nt1_q, inl2_0_q, inl2_1_q;
  logic [SETS-1:0] lru_q;

  function automatic logic [pffp_pkg::SET_W-1:0] set_of(
    input logic [pffp_pkg::ADDR_W-1:0] a);
    set_of = a[pffp_pkg::SET_LSB +: pffp_pkg::SET_W];
  endfunction : set_of

  function automatic logic [pffp_pkg::TAG_W-1:0] tag_of(
    input logic [pffp_pkg::ADDR_W-1:0] a);
    tag_of = a[pffp_pkg::TAG_LSB +: pffp_pkg::TAG_W];
  endfunction : tag_of

  logic [pffp_pkg::SET_W-1:0] s;
  logic [pffp_pkg::TAG_W-1:0] t;
  logic hit0, hit1, miss, vway, is_nt, is_wr, known;
  logic victim_vld, victim_nt, victim_inl2, victim_mod;
  logic [pffp_pkg::TAG_W-1:0] victim_tag;

  always_comb begin
    s     = set_of(req.addr);
    t     = tag_of(req.addr);
    hit0  = vld0_q[s] && (tag_mem[s][0] == t);
    hit1  = vld1_q[s] && (tag_mem[s][1] == t);
    miss  = !(hit0 || hit1);
    vway  = !vld0_q[s] ? 1'b0 : (!vld1_q[s] ? 1'b1 : lru_q[s]);
    known = (req.kind == pffp_pkg::KIND_PLAIN) ||
            (req.kind == pffp_pkg::KIND_HINT0) ||
            (req.kind == pffp_pkg::KIND_HINT1) ||
            (req.kind == pffp_pkg::KIND_HINT2) ||
            (req.kind == pffp_pkg::KIND_WRITE) ||
            (req.kind == pffp_pkg::KIND_NTMP);
    is_nt = (req.kind == pffp_pkg::KIND_NTMP) || (req.hw && req.hw_nt);
    is_wr = (req.kind == pffp_pkg::KIND_WRITE);
    victim_vld  = vway ? vld1_q[s] : vld0_q[s];
    victim_nt   = vway ? nt1_q[s] : nt0_q[s];
    victim_inl2 = vway ? inl2_1_q[s] : inl2_0_q[s];
    victim_mod  = vway ? mod1_q[s] : mod0_q[s];
    victim_tag  = tag_mem[s][vway];
  end

  logic take;
  assign take = req_valid && known;

  always_ff @(posedge sys_clk) begin
    if (take && miss) begin
      tag_mem[s][vway] <= t;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vld0_q   <= '0;
      vld1_q   <= '0;
      mod0_q   <= '0;
      mod1_q   <= '0;
      nt0_q    <= '0;
      nt1_q    <= '0;
      inl2_0_q <= '0;
      inl2_1_q <= '0;
      lru_q    <= '0;
    end else if (take) begin
      if (miss) begin
        if (vway) begin
          vld1_q[s]   <= 1'b1;
          mod1_q[s]   <= is_wr;
          nt1_q[s]    <= is_nt;
          inl2_1_q[s] <= req.l2_hit;
        end else begin
          vld0_q[s]   <= 1'b1;
          mod0_q[s]   <= is_wr;
          nt0_q[s]    <= is_nt;
          inl2_0_q[s] <= req.l2_hit;
        end
        lru_q[s] <= ~vway;
      end else begin
        // Write intent on a hit upgrades the line without a refetch.
        if (hit0 && is_wr) mod0_q[s] <= 1'b1;
        if (hit1 && is_wr) mod1_q[s] <= 1'b1;
        lru_q[s] <= hit0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evict_q <= '0;
    end else begin
      evict_q.valid      <= take && miss && victim_vld;
      evict_q.addr       <= {victim_tag, s, {pffp_pkg::LINE_OFS_W{1'b0}}};
      evict_q.install_l2 <= !victim_nt || victim_inl2;
      evict_q.dirty      <= victim_mod;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fill_q <= '0;
      hit_q  <= 1'b0;
    end else begin
      fill_q.valid           <= take && miss;
      fill_q.set             <= s;
      fill_q.tag             <= t;
      fill_q.way             <= vway;
      fill_q.modified        <= is_wr;
      fill_q.nontemporal_tag <= is_nt;
      fill_q.in_l2           <= req.l2_hit;
      hit_q                  <= take && !miss;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      train_q <= '0;
    end else begin
      train_q.valid           <= take && miss && !req.hw;
      train_q.addr            <=
        {req.addr[pffp_pkg::ADDR_W-1:pffp_pkg::LINE_OFS_W],
         {pffp_pkg::LINE_OFS_W{1'b0}}};
      train_q.nontemporal_tag <= is_nt;
    end
  end

  AST_NT_NO_INSTALL: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss && victim_vld && victim_nt && !victim_inl2
    |=> evict_q.valid && !evict_q.install_l2)
    else $error("Nontemporal line installed in second level.");
  // A tagged stream request may carry a hint kind, so it is left out here.
  AST_HINT_PLAIN: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss && !(req.hw && req.hw_nt) &&
    ((req.kind == pffp_pkg::KIND_PLAIN) ||
     (req.kind == pffp_pkg::KIND_HINT0) ||
     (req.kind == pffp_pkg::KIND_HINT1) ||
     (req.kind == pffp_pkg::KIND_HINT2))
    |=> fill_q.valid && !fill_q.modified && !fill_q.nontemporal_tag)
    else $error("Hint prefetch not filled as plain.");
  AST_IGNORE_UNKNOWN: assert property (
    @(posedge sys_clk) disable iff (reset)
    req_valid && !known
    |=> !fill_q.valid && !hit_q && !train_q.valid && !evict_q.valid)
    else $error("Unknown kind changed the cache.");
  AST_WRITE_MOD: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss && is_wr |=> fill_q.valid && fill_q.modified)
    else $error("Write-intent fill not modified.");
  AST_NT_TRAIN: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss && !req.hw && (req.kind == pffp_pkg::KIND_NTMP)
    |=> train_q.valid && train_q.nontemporal_tag)
    else $error("Nontemporal miss did not train.");
  AST_HW_NO_TRAIN: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && req.hw |=> !train_q.valid)
    else $error("Stream request trained the prefetcher.");
  AST_HW_NT_TAG: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss && req.hw && req.hw_nt |=> fill_q.nontemporal_tag)
    else $error("Stream fill lost its tag.");
  AST_ALIAS: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss
    |=> fill_q.set == $past(req.addr[pffp_pkg::SET_LSB +: pffp_pkg::SET_W]))
    else $error("Set index wrong.");
  AST_EVICT_SET: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss && victim_vld
    |=> evict_q.addr[pffp_pkg::SET_LSB +: pffp_pkg::SET_W] == fill_q.set)
    else $error("Victim taken from another set.");
  AST_NO_HIT_FILL: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && !miss |=> hit_q && !fill_q.valid && !evict_q.valid)
    else $error("Hit caused a refill.");
  AST_L2_WB: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss && victim_vld && victim_inl2 |=> evict_q.install_l2)
    else $error("Line from second level not written back.");
  AST_FLAGS: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss |=> fill_q.in_l2 == $past(req.l2_hit))
    else $error("Fill flag not recorded.");
  AST_TEMPORAL_WB: assert property (
    @(posedge sys_clk) disable iff (reset)
    take && miss && victim_vld && !victim_nt |=> evict_q.install_l2)
    else $error("Temporal line not written back.");
endmodule : pffp_fill_policy
`default_nettype wire

/* bench/pffp_lsu_model.sv */
// Stand-in for the load/store pipeline that issues prefetches.
// Assumes the bench changes go and cmd at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module pffp_lsu_model (
  // Bench side.
  input  wire logic                go,
  input  var  pffp_pkg::pffp_req_t cmd,
  // Pins toward the block.
  output logic                     req_valid,
  output var  pffp_pkg::pffp_req_t req
);
  assign req_valid = go;
  // Idle pins show the inverse, so stale request fields never look settled.
  assign req = go ? cmd : ~cmd;
endmodule : pffp_lsu_model
`default_nettype wire

/* bench/test_prefetch_fill_policy.sv */
// Self-checking bench for the prefetch fill policy block.
// Assumes a two-way cache, lowest free way first, then least recent.
`timescale 1ns/1ps
`default_nettype none
module test_prefetch_fill_policy;
  logic                  sys_clk, reset, go, req_valid, hit_q, e_hit;
  pffp_pkg::pffp_req_t   cmd, req;
  pffp_pkg::pffp_fill_t  fill_q, e_fill;
  pffp_pkg::pffp_evict_t evict_q, e_ev;
  pffp_pkg::pffp_train_t train_q, e_tr;
  logic [32:0]           mtag [512][2];
  bit                    mv [512][2], mm [512][2], mnt [512][2];
  bit                    ml2 [512][2], lru [512];
  int                    err_total, check_count;
  logic [31:0]           rnd;

  pffp_fill_policy i_pffp_fill_policy (.sys_clk(sys_clk), .reset(reset),
    .req_valid(req_valid), .req(req), .fill_q(fill_q), .evict_q(evict_q),
    .train_q(train_q), .hit_q(hit_q));
  pffp_lsu_model i_pffp_lsu_model (.go(go), .cmd(cmd),
    .req_valid(req_valid), .req(req));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] l);
    return {l[30:0], 1'b0} ^ (l[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr

  function automatic pffp_pkg::pffp_req_t mk(input logic [2:0] k,
      input logic [47:0] a, input logic l2, hw, nt);
    return {k, a, l2, hw, nt};
  endfunction : mk

  task automatic chk(input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Reference cache: works out the outputs one request should cause.
  function automatic void predict(input pffp_pkg::pffp_req_t r);
    logic [8:0]  s;
    logic [32:0] t;
    int          w;
    s = r.addr[14:6];
    t = r.addr[47:15];
    e_fill = '0;
    e_ev = '0;
    e_tr = '0;
    e_hit = 1'b0;
    if (r.kind > pffp_pkg::KIND_NTMP) return;
    w = (mv[s][1] && mtag[s][1] == t) ? 1 : 0;
    if (mv[s][w] && mtag[s][w] == t) begin
      e_hit = 1'b1;
      mm[s][w] |= (r.kind == pffp_pkg::KIND_WRITE);
    end else begin
      w = !mv[s][0] ? 0 : !mv[s][1] ? 1 : int'(lru[s]);
      e_ev = {mv[s][w], mtag[s][w], s, 6'h0, !mnt[s][w] || ml2[s][w],
              mm[s][w]};
      mv[s][w] = 1'b1;
      mtag[s][w] = t;
      mm[s][w] = (r.kind == pffp_pkg::KIND_WRITE);
      mnt[s][w] = (r.kind == pffp_pkg::KIND_NTMP) || (r.hw && r.hw_nt);
      ml2[s][w] = r.l2_hit;
      e_fill = {1'b1, s, t, w[0], mm[s][w], mnt[s][w], ml2[s][w]};
      e_tr = {!r.hw, r.addr[47:6], 6'h0, r.kind == pffp_pkg::KIND_NTMP};
    end
    lru[s] = !w[0];
  endfunction : predict

  task automatic step(input bit v, input pffp_pkg::pffp_req_t r);
    @(negedge sys_clk);
    chk(64'(fill_q.valid), 64'(e_fill.valid));
    if (e_fill.valid) chk(64'(fill_q), 64'(e_fill));
    chk(64'(evict_q.valid), 64'(e_ev.valid));
    if (e_ev.valid) chk(64'(evict_q), 64'(e_ev));
    chk(64'(train_q.valid), 64'(e_tr.valid));
    if (e_tr.valid) chk(64'(train_q), 64'(e_tr));
    chk(64'(hit_q), 64'(e_hit));
    go = v;
    cmd = r;
    predict(v ? r : '1);
  endtask : step

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial begin
    #(40 * 8000);
    err_total++;
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    go = 1'b0;
    cmd = '0;
    predict('1);
    rnd = 32'h8E62837C;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    // Two passes; the reset between them must leave every line invalid.
    for (int p = 0; p < 2; p++) begin
      // Every kind into one set, one way capacity apart: forces evictions.
      for (int k = 0; k < 8; k++) begin
        step(1'b1, mk(3'(k), (48'(k) << 15) | 48'h143, k[0], 1'b0, 1'b0));
      end
      step(1'b1, mk(pffp_pkg::KIND_PLAIN, 48'h20143, 1'b0, 1'b0, 1'b0));
      for (int i = 0; i < 1500; i++) begin
        rnd = lfsr(rnd);
        step(rnd[17], mk(rnd[2:0], 48'({rnd[4:3], 7'h0, rnd[6:5], rnd[12:7]}),
             rnd[13], rnd[14] & rnd[15], rnd[16]));
      end
      step(1'b0, '0);
      // Mid-run reset: outputs must stay low while it is held.
      reset = 1'b1;
      step(1'b0, '0);
      reset = 1'b0;
      for (int i = 0; i < 512; i++) begin
        mv[i][0] = 1'b0;
        mv[i][1] = 1'b0;
        lru[i] = 1'b0;
      end
    end
    step(1'b0, '0);
    end_of_test();
  end
endmodule : test_prefetch_fill_policy
`default_nettype wire
